// ===== rtl/pism_pkg.sv
package pism_pkg;
	// configuration byte offsets
	localparam logic [7:0] ROUTE_A_OFS  = 8'h60;
	localparam logic [7:0] ROUTE_D_OFS  = 8'h63;
	localparam logic [7:0] MEM_LIM_OFS  = 8'h69;
	// reset values
	localparam logic [7:0] ROUTE_RST    = 8'h80;
	localparam logic [7:0] MEM_LIM_RST  = 8'h02;
	// route register fields
	localparam int         ROUTE_DIS_BIT = 7;
	localparam logic [7:0] ROUTE_WMASK  = 8'h8F;
	// memory limit register fields
	localparam int         LIM_LSB      = 4;
	localparam int         LOWBIOS_BIT  = 3;
	localparam int         ABSEG_BIT    = 2;
	localparam int         SEG89_BIT    = 1;
	localparam logic [7:0] MEM_LIM_WMASK = 8'hFE;
	// decode windows, address bits [23:16]
	localparam logic [7:0] SEG_80_HI    = 8'h08;
	localparam logic [7:0] SEG_90_HI    = 8'h09;
	localparam logic [7:0] SEG_A0_HI    = 8'h0A;
	localparam logic [7:0] SEG_B0_HI    = 8'h0B;
	localparam logic [7:0] SEG_E0_HI    = 8'h0E;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  ofs;
		logic [7:0]  wdata;
	} pism_cfg_req_t;

	typedef struct packed {
		logic        valid;
		logic [23:0] addr;
	} pism_mem_req_t;
endpackage

// ===== rtl/pism_route_dec.sv
module pism_route_dec (
	// route register value
	input  wire logic [7:0]  i_route,
	// one-hot controller input select, bit n = input n
	output logic      [15:0] o_sel
);
	import pism_pkg::*;

	always_comb begin
		o_sel = 16'h0000;
		if (!i_route[ROUTE_DIS_BIT]) begin // [R3]
			case (i_route[3:0]) // [R5]
				4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF:
					o_sel[i_route[3:0]] = 1'b1;
				default: o_sel = 16'h0000; // [R15]
			endcase
		end
	end
endmodule // pism_route_dec

// ===== rtl/pism_cfg.sv
// Overview of operation
// [R1] route registers reset to 80h, steering off
// [R2] each line steers independently to eleven inputs
// [R3] bit 7 low enables steering
// [R4] route bits 6:4 read zero
// [R5] target code selects same-numbered controller input
// [R6] steered input masks its ISA pin
// [R7] software sets steered inputs level sensitive
// [R8] limit field gives n+1 megabytes forwarded
// [R9] software uses 15 MB with hole
// [R10] bit 3 forwards E segment unless chip-select
// [R11] bit 2 forwards A and B segments
// [R12] bit 1 forwards 80000-9FFFFh region
// [R13] firmware programs limit before masters rely
// [R14] lower BIOS enable drives chip select
// [R15] reserved target code connects and masks nothing
module pism_cfg (
	// clock and reset
	input  wire logic                    I_CLK,
	input  wire logic                    I_SYS_RST,
	// configuration access
	input  wire pism_pkg::pism_cfg_req_t I_CFG,
	output logic                   [7:0] O_CFG_RDATA,
	// external chip-select config, lower BIOS enable
	input  wire logic                    I_LOWBIOS_EN,
	// interrupt lines and ISA pins
	input  wire logic              [3:0] I_PCI_INT_N,
	input  wire logic             [15:0] I_ISA_IRQ,
	output logic                  [15:0] O_CTRL_IRQ,
	// ISA or DMA master memory cycle
	input  wire pism_pkg::pism_mem_req_t I_MEM,
	output logic                         O_FWD_PCI,
	output logic                         O_BIOS_CS_N,
	output logic                         O_XOE_N
);
	import pism_pkg::*;

	logic [7:0]  route_r [4];
	logic [7:0]  route_nxt [4];
	logic [7:0]  lim_r, lim_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	logic [15:0] irq_r, irq_nxt;
	logic        fwd_r, fwd_nxt, cs_n_r, cs_n_nxt;
	logic [15:0] sel [4];
	logic [15:0] steer_hit, steer_lvl;
	logic        in_lim, in_89, in_ab, in_e;

	// upper address byte match, shared by every segment decode
	function automatic logic seg_hit(input logic [23:0] addr, input logic [7:0] hi);
		return addr[23:16] == hi;
	endfunction

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_dec
			pism_route_dec u_dec (
				.i_route (route_r[g]),
				.o_sel   (sel[g])
			);
		end
	endgenerate

	// register writes; write masks keep reserved bits from latching
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			route_nxt[i] = route_r[i];
			if (I_CFG.wr && I_CFG.ofs == ROUTE_A_OFS + 8'(i))
				route_nxt[i] = I_CFG.wdata & ROUTE_WMASK; // [R4]
		end
		lim_nxt = lim_r;
		if (I_CFG.wr && I_CFG.ofs == MEM_LIM_OFS)
			lim_nxt = I_CFG.wdata & MEM_LIM_WMASK;
		rdata_nxt = 8'h00;
		if (I_CFG.rd) begin
			if (I_CFG.ofs >= ROUTE_A_OFS && I_CFG.ofs <= ROUTE_D_OFS)
				rdata_nxt = route_r[I_CFG.ofs[1:0]]; // [R4]
			else if (I_CFG.ofs == MEM_LIM_OFS)
				rdata_nxt = lim_r;
		end
	end

	// interrupt steering, several lines may share one input
	always_comb begin
		steer_hit = 16'h0000;
		steer_lvl = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			steer_hit = steer_hit | sel[i]; // [R2]
			if (!I_PCI_INT_N[i])
				steer_lvl = steer_lvl | sel[i];
		end
		irq_nxt = (I_ISA_IRQ & ~steer_hit) | steer_lvl; // [R6]
	end

	// memory forwarding decode
	always_comb begin
		in_lim = I_MEM.addr[23:20] <= lim_r[7:LIM_LSB]; // [R8]
		in_89  = seg_hit(I_MEM.addr, SEG_80_HI) || seg_hit(I_MEM.addr, SEG_90_HI);
		in_ab  = seg_hit(I_MEM.addr, SEG_A0_HI) || seg_hit(I_MEM.addr, SEG_B0_HI);
		in_e   = seg_hit(I_MEM.addr, SEG_E0_HI);
		fwd_nxt  = 1'b0;
		cs_n_nxt = 1'b1;
		if (I_MEM.valid) begin
			if (in_e) begin
				cs_n_nxt = !I_LOWBIOS_EN; // [R14]
				fwd_nxt = lim_r[LOWBIOS_BIT] && !I_LOWBIOS_EN; // [R10]
			end else if (in_ab)
				fwd_nxt = lim_r[ABSEG_BIT]; // [R11]
			else if (in_89)
				fwd_nxt = lim_r[SEG89_BIT]; // [R12]
			else
				fwd_nxt = in_lim; // [R8]
		end
	end

	// configuration registers and read data
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			for (int i = 0; i < 4; i++)
				route_r[i] <= ROUTE_RST; // [R1]
			lim_r   <= MEM_LIM_RST;
			rdata_r <= 8'h00;
		end else begin
			for (int i = 0; i < 4; i++)
				route_r[i] <= route_nxt[i];
			lim_r   <= lim_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// steered controller inputs
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			irq_r <= 16'h0000;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// chip select kept active low in the flop so the pins need no gate
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			fwd_r  <= 1'b0;
			cs_n_r <= 1'b1;
		end else begin
			fwd_r  <= fwd_nxt;
			cs_n_r <= cs_n_nxt;
		end
	end

	assign O_CFG_RDATA = rdata_r;
	assign O_CTRL_IRQ  = irq_r;
	assign O_FWD_PCI   = fwd_r;
	assign O_BIOS_CS_N = cs_n_r;
	assign O_XOE_N     = cs_n_r;

	a_route_reset: assert property (@(posedge I_CLK) // [R1]
		$fell(I_SYS_RST) |-> route_r[0] == ROUTE_RST && route_r[3] == ROUTE_RST)
		else $error("route reset value wrong");
	a_resv_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R4]
		$past(I_CFG.rd) && $past(I_CFG.ofs) == ROUTE_A_OFS |-> O_CFG_RDATA[6:4] == 3'h0)
		else $error("reserved route bits not zero");
	a_disabled_off: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R3]
		route_r[0][ROUTE_DIS_BIT] |-> sel[0] == 16'h0000)
		else $error("disabled line still steered");
	a_steer_map: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R5]
		!route_r[1][ROUTE_DIS_BIT] && route_r[1][3:0] == 4'h9 |-> sel[1] == 16'h0200)
		else $error("code 9 not on input 9");
	a_resv_code: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R15]
		route_r[2][3:0] == 4'hD || route_r[2][3:0] == 4'h8 |-> sel[2] == 16'h0000)
		else $error("reserved code steered");
	a_isa_mask: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R6]
		steer_hit[5] && I_PCI_INT_N == 4'hF |=> !O_CTRL_IRQ[5])
		else $error("ISA pin not masked");
	a_shared_in: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R2]
		sel[0] == sel[3] && sel[0] != 16'h0000 && !I_PCI_INT_N[3] |=> (O_CTRL_IRQ & sel[0]) != 0)
		else $error("shared input lost line");
	a_lim_fwd: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R8]
		I_MEM.valid && I_MEM.addr[23:20] > lim_r[7:4] |=> !O_FWD_PCI)
		else $error("forwarded above limit");
	a_e_block: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R10]
		I_MEM.valid && in_e && I_LOWBIOS_EN |=> !O_FWD_PCI && !O_BIOS_CS_N)
		else $error("E segment misrouted");
	a_ab_fwd: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R11]
		I_MEM.valid && in_ab |=> O_FWD_PCI == $past(lim_r[ABSEG_BIT]))
		else $error("A/B segment misrouted");
	a_89_fwd: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R12]
		I_MEM.valid && in_89 |=> O_FWD_PCI == $past(lim_r[SEG89_BIT]))
		else $error("80000 region misrouted");

	// further register, steering and forwarding checks
	a_ab_default: assert property (@(posedge I_CLK) // [R11]
		$fell(I_SYS_RST) |-> !lim_r[ABSEG_BIT])
		else $error("A/B forwarding on after reset");
	a_route_wmask: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R4]
		I_CFG.wr && I_CFG.ofs == ROUTE_D_OFS |=> route_r[3][6:4] == 3'h0)
		else $error("reserved route bits stored");
	a_lim_rd: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R8]
		I_CFG.rd && I_CFG.ofs == MEM_LIM_OFS |=> O_CFG_RDATA == $past(lim_r))
		else $error("limit read back wrong");
	a_route_dec: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R5]
		!route_r[3][ROUTE_DIS_BIT] && route_r[3][3:0] == 4'hE |-> sel[3] == 16'h4000)
		else $error("code 14 not on input 14");
	a_irq_pass: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R15]
		steer_hit == 16'h0000 |=> O_CTRL_IRQ == $past(I_ISA_IRQ))
		else $error("unsteered ISA pin altered");
	a_e_fwd: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R10]
		I_MEM.valid && in_e && !I_LOWBIOS_EN |=> O_FWD_PCI == $past(lim_r[LOWBIOS_BIT]))
		else $error("E segment forwarding wrong");
	a_cs_only_e: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R14]
		!(I_MEM.valid && in_e && I_LOWBIOS_EN) |=> O_BIOS_CS_N && O_XOE_N)
		else $error("chip select outside E segment");
	a_lim_in: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R8]
		I_MEM.valid && in_lim && !in_e && !in_ab && !in_89 |=> O_FWD_PCI)
		else $error("below limit not forwarded");
	a_idle_nofwd: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // [R8]
		!I_MEM.valid |=> !O_FWD_PCI)
		else $error("forwarded without a cycle");

	c_steer: cover property (@(posedge I_CLK) steer_hit != 16'h0000);
	c_fwd_e: cover property (@(posedge I_CLK) I_MEM.valid && in_e ##1 O_FWD_PCI);
	c_bios_cs: cover property (@(posedge I_CLK) !O_BIOS_CS_N);
	c_fwd_lim: cover property (@(posedge I_CLK) I_MEM.valid && in_lim ##1 O_FWD_PCI);
	c_shared: cover property (@(posedge I_CLK) sel[0] == sel[3] && sel[0] != 16'h0000);
endmodule // pism_cfg

// ===== dv/pism_host_mdl.sv
module pism_host_mdl (
	// clock
	input  wire logic             i_clk,
	// configuration access toward the block
	output pism_pkg::pism_cfg_req_t o_cfg
);
	timeunit 1ns;
	timeprecision 1ps;
	import pism_pkg::*;

	initial o_cfg = '0;

	// one access, dropped a cycle later so calls never overlap
	// steered inputs are taken as set level sensitive elsewhere
	task automatic acc(input logic w, input logic [7:0] ofs, input logic [7:0] d);
		@(negedge i_clk);
		o_cfg = '{wr: w, rd: !w, ofs: ofs, wdata: d};
		@(negedge i_clk);
		o_cfg = '0;
	endtask
endmodule // pism_host_mdl

// ===== dv/pism_cfg_tb.sv
module pism_cfg_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pism_pkg::*;

	logic          clk     = 1'b0;
	logic          rst     = 1'b1;
	logic          lowbios = 1'b0;
	logic [3:0]    pci_n   = 4'hF;
	logic [15:0]   isa     = 16'h0000;
	logic [15:0]   irq;
	logic [15:0]   sel;
	logic [7:0]    rdata;
	logic          fwd;
	logic          cs_n;
	logic          xoe_n;
	pism_mem_req_t mem     = '0;
	pism_cfg_req_t cfg;
	int            num_errors = 0;
	int            checks     = 0;
	int            cycles     = 0;
	// limit byte, lowbios, address, {fwd, cs_n}; limit E with hole at 15 MB
	logic [39:0]   tbl [11] = '{40'hEE_0_0E1234_3, 40'hEE_1_0E1234_0, 40'hE6_0_0E1234_1,
		40'hEE_0_0A0000_3, 40'hEA_0_0B0000_1, 40'hEE_0_090000_3, 40'hEC_0_080000_1,
		40'hEE_0_E00000_3, 40'hEE_0_F00000_1, 40'h02_0_0FFFFF_3, 40'h02_0_100000_1};

	pism_host_mdl host_u (.i_clk(clk), .o_cfg(cfg));
	pism_cfg dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_CFG(cfg), .O_CFG_RDATA(rdata),
		.I_LOWBIOS_EN(lowbios), .I_PCI_INT_N(pci_n), .I_ISA_IRQ(isa), .O_CTRL_IRQ(irq),
		.I_MEM(mem), .O_FWD_PCI(fwd), .O_BIOS_CS_N(cs_n), .O_XOE_N(xoe_n));

	initial forever #12.5 clk = ~clk;

	// whole run is a few hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		host_u.acc(1'b0, ofs, 8'h00);
		chk("rdata", {8'h00, rdata}, {8'h00, exp});
	endtask

	task automatic settle();
		repeat (2) @(negedge clk);
	endtask

	task automatic t_regs();
		for (int i = 0; i < 4; i++) rd(8'(8'h60 + i), 8'h80);
		rd(MEM_LIM_OFS, 8'h02);
		@(negedge clk);
		chk("rdata_idle", {8'h00, rdata}, 16'h0000);
		rd(8'h64, 8'h00);
		host_u.acc(1'b1, ROUTE_A_OFS, 8'hFF);
		rd(ROUTE_A_OFS, 8'h8F);
		host_u.acc(1'b1, MEM_LIM_OFS, 8'hFF);
		rd(MEM_LIM_OFS, 8'hFE);
	endtask

	// codes go to line C, so lines A, B and D stay out of the way
	task automatic t_codes();
		for (int c = 0; c < 16; c++) begin
			sel = ((16'hDEF8 >> c) & 16'h1) != 0 ? 16'h1 << c : 16'h0000;
			host_u.acc(1'b1, ROUTE_A_OFS + 8'h02, 8'(c));
			isa = 16'hFFFF;
			pci_n = 4'hF;
			settle();
			chk("mask", irq, ~sel);
			isa = 16'h0000;
			pci_n = 4'hB;
			settle();
			chk("steer", irq, sel);
		end
		host_u.acc(1'b1, ROUTE_A_OFS + 8'h02, 8'h85);
		isa = 16'hFFFF;
		pci_n = 4'h0;
		settle();
		chk("off", irq, 16'hFFFF);
	endtask

	task automatic t_lines();
		isa = 16'h0000;
		host_u.acc(1'b1, ROUTE_A_OFS, 8'h09);
		for (int i = 1; i < 4; i++) host_u.acc(1'b1, 8'(8'h60 + i), 8'h70 | 8'(8 + i));
		rd(ROUTE_D_OFS, 8'h0B);
		for (int i = 0; i < 4; i++) begin
			pci_n = ~(4'h1 << i);
			settle();
			chk("line", irq, 16'h1 << (i == 0 ? 9 : 8 + i));
		end
		for (int i = 0; i < 4; i++) host_u.acc(1'b1, 8'(8'h60 + i), 8'h0E);
		pci_n = 4'h7;
		settle();
		chk("shared", irq, 16'h4000);
		isa = 16'hFFFF;
		pci_n = 4'hF;
		settle();
		chk("shared_mask", irq, 16'hBFFF);
	endtask

	// mid-run reset with chip select active and steering set up
	task automatic t_reset();
		@(negedge clk);
		mem = '{valid: 1'b1, addr: 24'h0E0000};
		lowbios = 1'b1;
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk("rst_cs", {14'h0000, cs_n, xoe_n}, 16'h0003);
		chk("rst_fwd", {15'h0000, fwd}, 16'h0000);
		chk("rst_irq", irq, 16'h0000);
		mem.valid = 1'b0;
		lowbios = 1'b0;
		rst = 1'b0;
		for (int i = 0; i < 4; i++) rd(8'(8'h60 + i), 8'h80);
		rd(MEM_LIM_OFS, 8'h02);
		chk("rst_pass", irq, 16'hFFFF);
	endtask

	task automatic t_mem();
		foreach (tbl[i]) begin
			host_u.acc(1'b1, MEM_LIM_OFS, tbl[i][39:32]);
			lowbios = tbl[i][28];
			mem = '{valid: 1'b1, addr: tbl[i][27:4]};
			@(negedge clk);
			mem.valid = 1'b0;
			chk("fwd", {15'h0000, fwd}, {15'h0000, tbl[i][1]});
			chk("cs", {14'h0000, cs_n, xoe_n}, {14'h0000, {2{tbl[i][0]}}});
		end
	endtask

	task automatic final_report();
		if (num_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		t_regs();
		t_codes();
		t_lines();
		t_mem();
		t_reset();
		final_report();
	end
endmodule // pism_cfg_tb
